// [design/pscr_pkg.sv]
/*
  pscr_pkg: constants, register offsets, field positions and carrier types
  for the pin i/o and scan control register group.
  assumes: an 8-bit register port driven by the serial front end.
*/
// Operation
// - direction bit: 0 input, 1 output
// - drive bit: 0 open-drain, 1 push-pull
// - output pin drives its level bit
// - read-only input levels, writes ignored
// - scan start acts only in auto mode
// - start cycles enabled channels, ascending order
// - writing zero stops auto sequencing
// - two-bit mode: manual, auto, on-the-fly, reserved
// - manual mode uses manual channel field
// - codes 0-7 pick channels; 1xxx reserved
// - pin function bit: 0 analog, 1 gpio
// - scan mask bit includes channel in sequence
// - force analog overrides all pin settings
package pscr_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] PIN_FUNCTION_OFS = 8'h05;
  localparam logic [7:0] PIN_DIRECTION_CTL_OFS = 8'h07;
  localparam logic [7:0] OUTPUT_DRIVE_TYPE_OFS = 8'h09;
  localparam logic [7:0] OUTPUT_LEVEL_SET_OFS = 8'h0B;
  localparam logic [7:0] INPUT_LEVEL_READ_OFS = 8'h0D;
  localparam logic [7:0] SCAN_CONTROL_OFS = 8'h10;
  localparam logic [7:0] MANUAL_CHANNEL_PICK_OFS = 8'h11;
  localparam logic [7:0] SCAN_ENABLE_MASK_OFS = 8'h12;

  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam int SCAN_START_BIT = 4;
  localparam int SCAN_MODE_LSB = 0;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] SCAN_CONTROL_MASK = 8'h13;
  localparam logic [7:0] MANUAL_CHANNEL_MASK = 8'h0F;
  localparam logic [3:0] CHAN_RESERVED_BIT = 4'h8;

  typedef enum logic [1:0] {
    PSCR_MODE_MANUAL = 2'h0,
    PSCR_MODE_AUTO = 2'h1,
    PSCR_MODE_OTF = 2'h2,
    PSCR_MODE_RSVD = 2'h3
  } pscr_mode_t;

  // register access from the serial front end
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pscr_req_t;

  // pin driver controls, one bit per shared pin
  typedef struct packed {
    logic [7:0] out_level;
    logic [7:0] out_en;
  } pscr_pin_t;

endpackage : pscr_pkg

// [design/pscr_regs.sv]
/*
  pscr_regs: pin direction, drive type, output level, input readback and
  channel scan control registers.
  assumes: reg requests synchronous to sys_clk_i; pin inputs synchronous;
  conv_done_i pulses once per finished conversion from the converter core.
*/
`timescale 1ns/1ps
`default_nettype none

module pscr_regs (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // register port
  input wire pscr_pkg::pscr_req_t req_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  // force analog control from the general config register
  input wire logic force_analog_i,
  // shared pins
  input wire logic [7:0] pin_i,
  output logic [7:0] pin_o,
  output logic [7:0] pin_oe_o,
  output logic [7:0] analog_sel_o,
  // converter handshake
  input wire logic conv_done_i,
  output logic [2:0] conv_channel_o,
  output logic conv_channel_valid_o,
  output logic auto_running_o
);

  // ---------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------
  logic [7:0] pin_function;
  logic [7:0] pin_direction_ctl;
  logic [7:0] output_drive_type_bits;
  logic [7:0] output_level_bits;
  logic [7:0] input_level_bits;
  logic scan_start;
  pscr_pkg::pscr_mode_t scan_mode;
  logic [3:0] manual_channel_field;
  logic [7:0] scan_enable_mask;
  logic [2:0] auto_channel;
  logic [7:0] rdata;
  logic rvalid;

  function automatic logic hit(input pscr_pkg::pscr_req_t r, input logic [7:0] ofs);
    hit = r.wr && (r.addr == ofs);
  endfunction : hit

  // next enabled channel strictly above cur, wrapping; cur if none other
  function automatic logic [2:0] next_enabled(input logic [7:0] mask, input logic [2:0] cur);
    logic [2:0] idx;
    next_enabled = cur;
    for (int k = 7; k >= 1; k--) begin
      idx = cur + k[2:0];
      if (mask[idx]) begin
        next_enabled = idx;
      end
    end
  endfunction : next_enabled

  // lowest enabled channel, 0 when none
  function automatic logic [2:0] first_enabled(input logic [7:0] mask);
    first_enabled = 3'h0;
    for (int k = 7; k >= 0; k--) begin
      if (mask[k]) begin
        first_enabled = k[2:0];
      end
    end
  endfunction : first_enabled

  // ---------------------------------------------------------------
  // pin control
  // ---------------------------------------------------------------
  wire [7:0] gpio_active = force_analog_i ? 8'h00 : pin_function;
  wire [7:0] out_pins = gpio_active & pin_direction_ctl;
  // open-drain only pulls low; the pull-up provides the high level
  wire [7:0] drive_en = out_pins & (output_drive_type_bits | ~output_level_bits);
  pscr_pkg::pscr_pin_t pins;
  assign pins.out_en = drive_en;
  assign pins.out_level = output_level_bits;
  assign pin_o = pins.out_level;
  assign pin_oe_o = pins.out_en;
  assign analog_sel_o = ~gpio_active;

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  wire wr_scan = hit(req_i, pscr_pkg::SCAN_CONTROL_OFS);
  wire wr_mask = hit(req_i, pscr_pkg::SCAN_ENABLE_MASK_OFS);
  wire [1:0] wr_mode = req_i.wdata[pscr_pkg::SCAN_MODE_LSB +: 2];
  wire wr_start = req_i.wdata[pscr_pkg::SCAN_START_BIT];

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      pin_function <= pscr_pkg::REG_RESET;
      pin_direction_ctl <= pscr_pkg::REG_RESET;
      output_drive_type_bits <= pscr_pkg::REG_RESET;
      output_level_bits <= pscr_pkg::REG_RESET;
      scan_enable_mask <= pscr_pkg::REG_RESET;
      manual_channel_field <= 4'h0;
      scan_mode <= pscr_pkg::PSCR_MODE_MANUAL;
      scan_start <= 1'b0;
    end else begin
      if (hit(req_i, pscr_pkg::PIN_FUNCTION_OFS)) pin_function <= req_i.wdata;
      if (hit(req_i, pscr_pkg::PIN_DIRECTION_CTL_OFS)) pin_direction_ctl <= req_i.wdata;
      if (hit(req_i, pscr_pkg::OUTPUT_DRIVE_TYPE_OFS)) output_drive_type_bits <= req_i.wdata;
      if (hit(req_i, pscr_pkg::OUTPUT_LEVEL_SET_OFS)) output_level_bits <= req_i.wdata;
      if (wr_mask) scan_enable_mask <= req_i.wdata;
      if (hit(req_i, pscr_pkg::MANUAL_CHANNEL_PICK_OFS)) manual_channel_field <= req_i.wdata[3:0];
      if (wr_scan) begin
        scan_mode <= pscr_pkg::pscr_mode_t'(wr_mode);
        scan_start <= wr_start;
      end
    end
  end

  // ---------------------------------------------------------------
  // channel sequencing
  // ---------------------------------------------------------------
  wire auto_run = scan_start && (scan_mode == pscr_pkg::PSCR_MODE_AUTO);
  wire start_edge = wr_scan && wr_start && (wr_mode == pscr_pkg::PSCR_MODE_AUTO);
  wire manual_ok = (manual_channel_field & pscr_pkg::CHAN_RESERVED_BIT) == 4'h0;
  wire mask_any = |scan_enable_mask;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      auto_channel <= 3'h0;
    end else if (start_edge || (wr_mask && !auto_run)) begin
      auto_channel <= first_enabled(wr_mask ? req_i.wdata : scan_enable_mask);
    end else if (auto_run && conv_done_i) begin
      auto_channel <= next_enabled(scan_enable_mask, auto_channel);
    end
  end

  // on-the-fly selection lives in the serial frame logic, not here
  always_comb begin
    conv_channel_o = 3'h0;
    conv_channel_valid_o = 1'b0;
    unique case (scan_mode)
      pscr_pkg::PSCR_MODE_MANUAL: begin
        conv_channel_o = manual_channel_field[2:0];
        conv_channel_valid_o = manual_ok;
      end
      pscr_pkg::PSCR_MODE_AUTO: begin
        conv_channel_o = auto_channel;
        conv_channel_valid_o = auto_run && mask_any;
      end
      pscr_pkg::PSCR_MODE_OTF: begin
        conv_channel_valid_o = 1'b0;
      end
      pscr_pkg::PSCR_MODE_RSVD: begin
        conv_channel_valid_o = 1'b0;
      end
    endcase
  end
  assign auto_running_o = auto_run;

  // ---------------------------------------------------------------
  // readback
  // ---------------------------------------------------------------
  wire [7:0] scan_rd = {3'h0, scan_start, 2'h0, scan_mode} & pscr_pkg::SCAN_CONTROL_MASK;
  logic [7:0] next_rdata;
  always_comb begin
    unique case (req_i.addr)
      pscr_pkg::PIN_FUNCTION_OFS: next_rdata = pin_function;
      pscr_pkg::PIN_DIRECTION_CTL_OFS: next_rdata = pin_direction_ctl;
      pscr_pkg::OUTPUT_DRIVE_TYPE_OFS: next_rdata = output_drive_type_bits;
      pscr_pkg::OUTPUT_LEVEL_SET_OFS: next_rdata = output_level_bits;
      pscr_pkg::INPUT_LEVEL_READ_OFS: next_rdata = input_level_bits;
      pscr_pkg::SCAN_CONTROL_OFS: next_rdata = scan_rd;
      pscr_pkg::MANUAL_CHANNEL_PICK_OFS: next_rdata = {4'h0, manual_channel_field} & pscr_pkg::MANUAL_CHANNEL_MASK;
      pscr_pkg::SCAN_ENABLE_MASK_OFS: next_rdata = scan_enable_mask;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      input_level_bits <= pscr_pkg::REG_RESET;
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      input_level_bits <= pin_i;
      rvalid <= req_i.rd;
      if (req_i.rd) rdata <= next_rdata;
    end
  end
  assign rdata_o = rdata;
  assign rvalid_o = rvalid;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_INPUT_RO: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    1'b1 |=> input_level_bits == $past(pin_i)) else $error("input level not sampled");
  AST_DIR: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (~pin_direction_ctl & pin_oe_o) == 8'h00) else $error("input pin driven");
  AST_OD: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (~output_drive_type_bits & pin_oe_o & pin_o) == 8'h00) else $error("open drain drove high");
  AST_LEVEL: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (pin_oe_o & (pin_o ^ output_level_bits)) == 8'h00) else $error("wrong output level");
  AST_AUTO_ONLY: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    scan_mode != pscr_pkg::PSCR_MODE_AUTO |-> !auto_running_o) else $error("start outside auto");
  AST_START: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    start_edge |=> auto_running_o) else $error("scan did not start");
  AST_STOP: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    wr_scan && !wr_start |=> !auto_running_o && !(scan_mode == pscr_pkg::PSCR_MODE_AUTO && conv_channel_valid_o))
    else $error("scan did not stop");
  AST_MODE: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    wr_scan |=> scan_mode == $past(wr_mode)) else $error("mode not stored");
  AST_MANUAL: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    scan_mode == pscr_pkg::PSCR_MODE_MANUAL && manual_ok |-> conv_channel_o == manual_channel_field[2:0])
    else $error("manual channel wrong");
  AST_RSVD_CHAN: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    manual_channel_field[3] |-> !(scan_mode == pscr_pkg::PSCR_MODE_MANUAL && conv_channel_valid_o))
    else $error("reserved channel used");
  AST_FUNC: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    !force_analog_i |-> analog_sel_o == ~pin_function) else $error("pin function wrong");
  AST_MASK: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    auto_run && conv_done_i && mask_any && !start_edge && !wr_scan && !wr_mask |=> scan_enable_mask[auto_channel])
    else $error("disabled channel scanned");
  AST_FORCE: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    force_analog_i |-> pin_oe_o == 8'h00 && analog_sel_o == 8'hFF) else $error("force analog ignored");
  AST_GPIO_ONLY: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (analog_sel_o & pin_oe_o) == 8'h00) else $error("analog pin driven");

  // ---------------------------------------------------------------
  // ordering helper: channel one step back
  // ---------------------------------------------------------------
  // check-only state; feeds no output, so it may lag freely
  logic [2:0] chk_prev_channel;
  logic chk_advanced;
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      chk_prev_channel <= 3'h0;
      chk_advanced <= 1'b0;
    end else begin
      chk_prev_channel <= auto_channel;
      chk_advanced <= auto_run && conv_done_i && !wr_mask && !wr_scan;
    end
  end
  wire [7:0] chk_below_new = (8'h01 << auto_channel) - 8'h01;
  wire [7:0] chk_upto_prev = (8'h02 << chk_prev_channel) - 8'h01;
  wire [7:0] chk_skipped = chk_below_new & ~chk_upto_prev;

  // ---------------------------------------------------------------
  // sequencing and reset checks
  // ---------------------------------------------------------------
  AST_ASCEND: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    chk_advanced && auto_channel > chk_prev_channel |-> (scan_enable_mask & chk_skipped) == 8'h00)
    else $error("enabled channel skipped");
  AST_WRAP: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    chk_advanced && auto_channel <= chk_prev_channel |->
      (scan_enable_mask & (~chk_upto_prev | chk_below_new)) == 8'h00)
    else $error("sequence wrapped too early");
  AST_RESTART: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    start_edge && mask_any |=> scan_enable_mask[auto_channel] && (scan_enable_mask & chk_below_new) == 8'h00)
    else $error("scan did not restart at lowest channel");
  AST_AUTO_VALID: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    auto_run && mask_any |-> conv_channel_valid_o && conv_channel_o == auto_channel)
    else $error("running scan gave no channel");
  AST_HOLD_STOPPED: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    !auto_run && !start_edge && !wr_mask |=> $stable(auto_channel))
    else $error("stopped scan moved");
  AST_RST_PINS: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    $past(sys_rst_i) |-> pin_oe_o == 8'h00 && analog_sel_o == 8'hFF && !auto_running_o)
    else $error("pins not idle after reset");

  // ---------------------------------------------------------------
  // storage, readback, drive and channel valid checks
  // ---------------------------------------------------------------
  AST_DIR_STORE: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    hit(req_i, pscr_pkg::PIN_DIRECTION_CTL_OFS) |=> pin_direction_ctl == $past(req_i.wdata))
    else $error("direction not stored");
  AST_DRIVE_STORE: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    hit(req_i, pscr_pkg::OUTPUT_DRIVE_TYPE_OFS) |=> output_drive_type_bits == $past(req_i.wdata))
    else $error("drive type not stored");
  AST_LEVEL_STORE: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    hit(req_i, pscr_pkg::OUTPUT_LEVEL_SET_OFS) |=> output_level_bits == $past(req_i.wdata))
    else $error("output level not stored");
  AST_PUSH_PULL: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    !force_analog_i |-> (pin_function & pin_direction_ctl & output_drive_type_bits & ~pin_oe_o) == 8'h00)
    else $error("push-pull output not driven");
  AST_DRIVE_LOW: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    !force_analog_i |-> (pin_function & pin_direction_ctl & ~output_level_bits & ~pin_oe_o) == 8'h00)
    else $error("low output not driven");
  AST_RDATA_IN: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    req_i.rd && req_i.addr == pscr_pkg::INPUT_LEVEL_READ_OFS |=> rvalid_o && rdata_o == $past(input_level_bits))
    else $error("input levels not returned");
  AST_RVALID_IDLE: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    !req_i.rd |=> !rvalid_o) else $error("read answer without read");
  AST_OTF_IDLE: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    scan_mode == pscr_pkg::PSCR_MODE_OTF || scan_mode == pscr_pkg::PSCR_MODE_RSVD |-> !conv_channel_valid_o)
    else $error("channel offered in other mode");
  AST_MANUAL_STORE: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    hit(req_i, pscr_pkg::MANUAL_CHANNEL_PICK_OFS) |=> manual_channel_field == $past(req_i.wdata[3:0]))
    else $error("manual channel not stored");
  AST_MANUAL_VALID: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    scan_mode == pscr_pkg::PSCR_MODE_MANUAL && !manual_channel_field[3] |-> conv_channel_valid_o)
    else $error("legal manual channel refused");
  AST_MASK_STORE: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    wr_mask |=> scan_enable_mask == $past(req_i.wdata))
    else $error("scan mask not stored");

endmodule : pscr_regs

`default_nettype wire

// [tb/pscr_host.sv]
/*
  pscr_host: host controller model issuing register writes and reads.
  assumes: requests taken on the rising edge, rvalid one cycle after rd.
*/
`timescale 1ns/1ps
`default_nettype none

module pscr_host (
  // clock
  input wire logic sys_clk_i,
  // register port
  output pscr_pkg::pscr_req_t req_o,
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i
);
  initial req_o = '0;

  // one idle cycle between requests; slower than back to back but safe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    #1 req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk_i);
    #1 req_o = '0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge sys_clk_i);
    #1 req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge sys_clk_i);
    #1;
    ok = rvalid_i;
    d = rdata_i;
    req_o = '0;
  endtask : rd
endmodule : pscr_host

`default_nettype wire

// [tb/tb_top.sv]
/*
  tb_top: register and pin tests for pscr_regs.
  assumes: pull-ups on all pins, external drive A4 where released.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  pscr_pkg::pscr_req_t req;
  logic [7:0] rdata, pin_in, pin_out, pin_oe, asel, v;
  logic rvalid, ok, chan_ok, running;
  logic force_an = 1'b0;
  logic done = 1'b0;
  logic [2:0] chan;
  logic [7:0] ext = 8'hA4;
  logic [7:0] ofs [6] = '{8'h07, 8'h09, 8'h0B, 8'h10, 8'h11, 8'h40};
  logic [2:0] seq [3] = '{3'h3, 3'h5, 3'h0};
  int n_errors = 0;
  int checks_done = 0;

  always #5 sys_clk_i = ~sys_clk_i;
  // released bits read the external drive level from ext
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);

  pscr_regs u_dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .req_i(req), .rdata_o(rdata),
    .rvalid_o(rvalid), .force_analog_i(force_an), .pin_i(pin_in), .pin_o(pin_out), .pin_oe_o(pin_oe),
    .analog_sel_o(asel), .conv_done_i(done), .conv_channel_o(chan), .conv_channel_valid_o(chan_ok),
    .auto_running_o(running));
  pscr_host u_host (.sys_clk_i(sys_clk_i), .req_o(req), .rdata_i(rdata), .rvalid_i(rvalid));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    u_host.rd(a, v, ok);
    chk({7'h00, ok}, 8'h01);
    chk(v, exp);
  endtask : rdchk

  task automatic pulse_done;
    @(posedge sys_clk_i);
    #1 done = 1'b1;
    @(posedge sys_clk_i);
    #1 done = 1'b0;
  endtask : pulse_done

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test

  initial begin
    #200000;
    n_errors++;
    finish_test();
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (8) @(posedge sys_clk_i);
    #1 sys_rst_i = 1'b0;
    foreach (ofs[i]) rdchk(ofs[i], 8'h00);
    chk(pin_oe, 8'h00);
    chk(asel, 8'hFF);
    chk({5'h00, chan}, 8'h00);
    $display("test reset done");
    u_host.wr(8'h05, 8'hFF);
    u_host.wr(8'h07, 8'h0F);
    u_host.wr(8'h09, 8'h03);
    u_host.wr(8'h0B, 8'h05);
    rdchk(8'h07, 8'h0F);
    rdchk(8'h09, 8'h03);
    rdchk(8'h0B, 8'h05);
    chk(pin_oe, 8'h0B);
    chk(pin_out & pin_oe, 8'h01);
    rdchk(8'h0D, 8'hA5);
    u_host.wr(8'h0D, 8'h5A);
    rdchk(8'h0D, 8'hA5);
    u_host.wr(8'h05, 8'h0E);
    chk(pin_oe, 8'h0A);
    chk(asel, 8'hF1);
    force_an = 1'b1;
    @(posedge sys_clk_i);
    #1 chk(pin_oe, 8'h00);
    chk(asel, 8'hFF);
    force_an = 1'b0;
    $display("test pins done");
    // all channels analog before manual picks
    u_host.wr(8'h05, 8'h00);
    for (int i = 0; i < 8; i++) begin
      u_host.wr(8'h11, 8'(i));
      chk({5'h00, chan}, 8'(i));
      chk({7'h00, chan_ok}, 8'h01);
    end
    u_host.wr(8'h11, 8'hFF);
    chk({7'h00, chan_ok}, 8'h00);
    rdchk(8'h11, 8'h0F);
    u_host.wr(8'h11, 8'h02);
    $display("test manual done");
    u_host.wr(8'h12, 8'h29);
    rdchk(8'h12, 8'h29);
    u_host.wr(8'h10, 8'h10);
    chk({7'h00, running}, 8'h00);
    chk({5'h00, chan}, 8'h02);
    u_host.wr(8'h10, 8'h11);
    chk({7'h00, running}, 8'h01);
    chk({5'h00, chan}, 8'h00);
    chk({7'h00, chan_ok}, 8'h01);
    rdchk(8'h10, 8'h11);
    foreach (seq[i]) begin
      pulse_done();
      chk({5'h00, chan}, {5'h00, seq[i]});
    end
    u_host.wr(8'h10, 8'h01);
    chk({7'h00, running}, 8'h00);
    chk({7'h00, chan_ok}, 8'h00);
    // a finished conversion must not move a stopped scan
    pulse_done();
    chk({5'h00, chan}, 8'h00);
    u_host.wr(8'h10, 8'h02);
    chk({7'h00, chan_ok}, 8'h00);
    u_host.wr(8'h10, 8'h03);
    chk({7'h00, chan_ok}, 8'h00);
    u_host.wr(8'h10, 8'hFF);
    rdchk(8'h10, 8'h13);
    u_host.wr(8'h10, 8'h00);
    chk({5'h00, chan}, 8'h02);
    chk({7'h00, chan_ok}, 8'h01);
    $display("test scan done");
    u_host.wr(8'h05, 8'hFF);
    chk(pin_oe, 8'h0B);
    sys_rst_i = 1'b1;
    repeat (2) @(posedge sys_clk_i);
    #1 sys_rst_i = 1'b0;
    chk(pin_oe, 8'h00);
    chk({5'h00, chan}, 8'h00);
    rdchk(8'h11, 8'h00);
    rdchk(8'h12, 8'h00);
    u_host.wr(8'h10, 8'h11);
    chk({7'h00, running}, 8'h01);
    chk({7'h00, chan_ok}, 8'h00);
    $display("test reset again done");
    finish_test();
  end
endmodule : tb_top

`default_nettype wire
